// file: aabm_defines.vh
// Register indices, field positions and reset values of the breakpoint unit.
`ifndef AABM_DEFINES_VH
`define AABM_DEFINES_VH
`define AABM_IDX_ATTR 5'h06
`define AABM_IDX_HIGH 5'h0C
`define AABM_IDX_LOW 5'h0D
`define AABM_ATTR_RESET 16'h0005
`define AABM_ADDR_RESET 32'h00000000
`define AABM_RM_BIT 15
`define AABM_SZM_HI 14
`define AABM_SZM_LO 13
`define AABM_TTM_HI 12
`define AABM_TTM_LO 11
`define AABM_TMM_HI 10
`define AABM_TMM_LO 8
`define AABM_R_BIT 7
`define AABM_SZ_HI 6
`define AABM_SZ_LO 5
`define AABM_TT_HI 4
`define AABM_TT_LO 3
`define AABM_TM_HI 2
`define AABM_TM_LO 0
`define AABM_ATTR_BITS 16
`define AABM_MODE_EXACT 2'h0
`define AABM_MODE_INSIDE 2'h1
`define AABM_MODE_OUTSIDE 2'h2
`define AABM_TT_NORMAL 2'h0
`define AABM_TT_EXTERNAL 2'h1
`define AABM_TT_EMULATOR 2'h2
`define AABM_TT_ACK 2'h3
`define AABM_TM_PUSH 3'h0
`define AABM_TM_USER_DATA 3'h1
`define AABM_TM_USER_CODE 3'h2
`define AABM_TM_SUPV_DATA 3'h5
`define AABM_TM_SUPV_CODE 3'h6
`endif

// file: aabm_match.v
// Address and attribute breakpoint comparator with its three registers.
`timescale 1ns/1ps
`include "aabm_defines.vh"
// Operation
// [RQ1] Compare stored attributes with each bus transfer.
// [RQ2] Direction mask bit 15 drops direction compare.
// [RQ3] Size mask bits drop matching size bits.
// [RQ4] Type mask bits drop matching type bits.
// [RQ5] Modifier mask bits drop matching modifier bits.
// [RQ6] Bit 7 compared with bus direction.
// [RQ7] Size field compared with bus size.
// [RQ8] Transfer type field compared with bus type.
// [RQ9] Type field drives debug memory command type.
// [RQ10] Modifier decode depends on transfer type.
// [RQ11] Normal mode modifier codes decoded.
// [RQ12] Emulator mode modifier codes decoded.
// [RQ13] Acknowledge space: CPU space, interrupt levels.
// [RQ14] Modifier field drives debug memory command.
// [RQ15] Compare address registers with every transfer.
// [RQ16] Exact mode hits on low address.
// [RQ17] Inside mode hits within inclusive bounds.
// [RQ18] Outside mode hits beyond either bound.
// [RQ19] Low register holds full 32-bit bound.
// [RQ20] High register holds full 32-bit bound.
// [RQ21] Debug memory commands overwrite shared registers.
// [RQ22] Attribute hit needs all unmasked bits equal.
// [RQ23] Range compares are unsigned 32-bit.
module aabm_match
(
  input wire i_clk,
  input wire i_resetn,
  input wire i_ce,
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [4:0] i_reg_idx,
  input wire [31:0] i_reg_wdata,
  output reg [31:0] o_reg_rdata,
  output reg o_reg_err,
  input wire i_cmd_load,
  input wire [31:0] i_cmd_addr,
  input wire [7:0] i_cmd_attr,
  output wire [31:0] o_cmd_addr,
  output wire [1:0] o_cmd_type,
  output wire [2:0] o_cmd_modifier,
  output wire [1:0] o_cmd_size,
  output wire o_cmd_read,
  input wire [1:0] i_addr_mode,
  input wire i_bus_valid,
  input wire [31:0] i_bus_addr,
  input wire i_bus_read,
  input wire [1:0] i_bus_size,
  input wire [1:0] i_bus_type,
  input wire [2:0] i_bus_modifier,
  output reg o_attr_hit,
  output reg o_addr_hit,
  output reg o_hit_valid,
  output reg [2:0] o_mod_class,
  output reg [2:0] o_int_level
);

  // ---------------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------------
  reg [15:0] attr_q;
  reg [31:0] low_q;
  reg [31:0] high_q;
  wire sel_attr;
  wire sel_low;
  wire sel_high;

  // Index decode; an unmapped index selects nothing.
  assign sel_attr = (i_reg_idx == `AABM_IDX_ATTR);
  assign sel_low = (i_reg_idx == `AABM_IDX_LOW);
  assign sel_high = (i_reg_idx == `AABM_IDX_HIGH);

  // A debug memory command wins over a host write, so a host write in the
  // same cycle as a command load is lost.
  always @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      attr_q <= `AABM_ATTR_RESET;
    else if (i_ce)
    begin
      if (i_cmd_load)
        attr_q[7:0] <= i_cmd_attr; // RQ21
      else if (i_reg_wr && sel_attr)
        attr_q <= i_reg_wdata[15:0];
    end
  end

  // The low bound is never shared with commands, so no write is blocked.
  always @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      low_q <= `AABM_ADDR_RESET;
    else if (i_ce)
    begin
      if (i_reg_wr && sel_low)
        low_q <= i_reg_wdata; // RQ19
    end
  end

  // The high bound doubles as the command address.
  always @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      high_q <= `AABM_ADDR_RESET;
    else if (i_ce)
    begin
      if (i_cmd_load)
        high_q <= i_cmd_addr; // RQ21
      else if (i_reg_wr && sel_high)
        high_q <= i_reg_wdata; // RQ20
    end
  end

  reg [31:0] rdata_d;
  wire reg_err_d;

  // Unmapped indices read as zero and raise the error pulse.
  always @*
  begin
    rdata_d = 32'h00000000;
    if (sel_attr)
      rdata_d = {16'h0000, attr_q};
    else if (sel_low)
      rdata_d = low_q;
    else if (sel_high)
      rdata_d = high_q;
  end

  assign reg_err_d = (i_reg_rd | i_reg_wr) & ~(sel_attr | sel_low | sel_high);

  always @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_reg_rdata <= 32'h00000000;
      o_reg_err <= 1'b0;
    end
    else if (i_ce)
    begin
      o_reg_err <= reg_err_d;
      if (i_reg_rd)
        o_reg_rdata <= rdata_d;
    end
  end

  // ---------------------------------------------------------------------
  // Attribute fields
  // ---------------------------------------------------------------------
  wire dir_mask;
  wire [1:0] size_mask;
  wire [1:0] type_mask;
  wire [2:0] mod_mask;
  wire dir_f;
  wire [1:0] size_f;
  wire [1:0] type_f;
  wire [2:0] tm_f;

  assign dir_mask = attr_q[`AABM_RM_BIT];
  assign size_mask = attr_q[`AABM_SZM_HI:`AABM_SZM_LO];
  assign type_mask = attr_q[`AABM_TTM_HI:`AABM_TTM_LO];
  assign mod_mask = attr_q[`AABM_TMM_HI:`AABM_TMM_LO];
  assign dir_f = attr_q[`AABM_R_BIT];
  assign size_f = attr_q[`AABM_SZ_HI:`AABM_SZ_LO];
  assign type_f = attr_q[`AABM_TT_HI:`AABM_TT_LO];
  assign tm_f = attr_q[`AABM_TM_HI:`AABM_TM_LO];

  // ---------------------------------------------------------------------
  // Debug memory command attributes
  // ---------------------------------------------------------------------
  // Commands read the shared fields directly, so a load shows from the next clock edge.
  assign o_cmd_addr = high_q;
  assign o_cmd_type = type_f; // RQ9
  assign o_cmd_modifier = tm_f; // RQ14
  assign o_cmd_size = size_f;
  assign o_cmd_read = dir_f;

  // ---------------------------------------------------------------------
  // Comparators
  // ---------------------------------------------------------------------
  wire dir_ok;
  wire [1:0] size_ok;
  wire [1:0] type_ok;
  wire [2:0] mod_ok;
  wire attr_ok;
  wire in_range;
  wire above_low;
  wire below_high;
  wire attr_hit_d;
  wire addr_hit_d;
  reg addr_ok;

  // A set mask bit forces its compare bit true.
  assign dir_ok = dir_mask | (dir_f == i_bus_read); // RQ2 RQ6
  assign size_ok = size_mask | ~(size_f ^ i_bus_size); // RQ3 RQ7
  assign type_ok = type_mask | ~(type_f ^ i_bus_type); // RQ4 RQ8
  assign mod_ok = mod_mask | ~(tm_f ^ i_bus_modifier); // RQ5
  assign attr_ok = dir_ok & (&size_ok) & (&type_ok) & (&mod_ok); // RQ1 RQ22

  // Unsigned vectors keep the bound tests unsigned.
  assign above_low = (i_bus_addr >= low_q); // RQ23
  assign below_high = (i_bus_addr <= high_q); // RQ23
  assign in_range = above_low & below_high;

  // Hits are qualified here so idle cycles never report a match.
  assign attr_hit_d = i_bus_valid & attr_ok; // RQ22
  assign addr_hit_d = i_bus_valid & addr_ok; // RQ15

  always @*
  begin
    case (i_addr_mode)
      `AABM_MODE_EXACT:
      begin
        addr_ok = (i_bus_addr == low_q); // RQ16
      end
      `AABM_MODE_INSIDE:
      begin
        addr_ok = in_range; // RQ17
      end
      `AABM_MODE_OUTSIDE:
      begin
        addr_ok = ~in_range; // RQ18
      end
      // Mode 3 is the never-hit setting.
      default:
      begin
        addr_ok = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------------
  // Modifier decode for the stored transfer type
  // ---------------------------------------------------------------------
  // Classes: 0 reserved, 1 push, 2 user data, 3 user code,
  // 4 privileged data, 5 privileged code, 6 CPU space, 7 interrupt ack.
  reg [2:0] cls;
  reg [2:0] lvl;

  always @*
  begin
    cls = 3'h0;
    lvl = 3'h0;
    case (type_f) // RQ10
      `AABM_TT_NORMAL:
      begin
        case (tm_f) // RQ11
          `AABM_TM_PUSH: cls = 3'h1;
          `AABM_TM_USER_DATA: cls = 3'h2;
          `AABM_TM_USER_CODE: cls = 3'h3;
          `AABM_TM_SUPV_DATA: cls = 3'h4;
          `AABM_TM_SUPV_CODE: cls = 3'h5;
          default: cls = 3'h0;
        endcase
      end
      // Emulator mode shares the privileged data and code classes.
      `AABM_TT_EMULATOR:
      begin
        case (tm_f) // RQ12
          `AABM_TM_SUPV_DATA: cls = 3'h4;
          `AABM_TM_SUPV_CODE: cls = 3'h5;
          default: cls = 3'h0;
        endcase
      end
      `AABM_TT_ACK:
      begin
        if (tm_f == 3'h0) // RQ13
          cls = 3'h6;
        else
        begin
          cls = 3'h7;
          lvl = tm_f; // RQ13
        end
      end
      default: cls = 3'h0;
    endcase
  end

  // ---------------------------------------------------------------------
  // Registered hit outputs, one result per bus transfer
  // ---------------------------------------------------------------------
  always @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_attr_hit <= 1'b0;
      o_addr_hit <= 1'b0;
      o_hit_valid <= 1'b0;
      o_mod_class <= 3'h0;
      o_int_level <= 3'h0;
    end
    else if (i_ce)
    begin
      o_hit_valid <= i_bus_valid; // RQ15
      o_attr_hit <= attr_hit_d; // RQ22
      o_addr_hit <= addr_hit_d; // RQ15
      // The class follows the stored setting, not the bus.
      o_mod_class <= cls;
      o_int_level <= lvl;
    end
  end

endmodule

// file: aabm_match_sva.sv
// Assertion checker for the breakpoint comparator ports.
`timescale 1ns/1ps
module aabm_match_sva
(
  input wire i_clk,
  input wire i_resetn,
  input wire i_ce,
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [4:0] i_reg_idx,
  input wire o_reg_err,
  input wire i_cmd_load,
  input wire [7:0] i_cmd_attr,
  input wire [1:0] o_cmd_type,
  input wire [2:0] o_cmd_modifier,
  input wire i_bus_valid,
  input wire o_attr_hit,
  input wire o_addr_hit,
  input wire o_hit_valid,
  input wire [2:0] o_mod_class,
  input wire [2:0] o_int_level
);
  reg [7:0] attr_q;
  always @(posedge i_clk)
    attr_q <= i_cmd_attr;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  chk_hit_follows: assert property
    (i_ce |=> o_hit_valid == $past(i_bus_valid)) else $error("hit lag");
  chk_attr_gated: assert property
    (o_attr_hit |-> o_hit_valid) else $error("attr hit without valid");
  chk_addr_gated: assert property
    (o_addr_hit |-> o_hit_valid) else $error("addr hit without valid");
  chk_cmd_type: assert property
    (i_ce && i_cmd_load |=> o_cmd_type == attr_q[4:3]) else $error("type");
  chk_cmd_mod: assert property
    (i_ce && i_cmd_load |=> o_cmd_modifier == attr_q[2:0]) else $error("mod");
  chk_int_class: assert property
    (o_int_level != 3'h0 |-> o_mod_class == 3'h7) else $error("level");
  chk_class_hold: assert property
    (!i_reg_wr && !i_cmd_load ##1 !i_reg_wr && !i_cmd_load
      |=> $stable(o_mod_class)) else $error("class moved");
  chk_err_unmapped: assert property
    (i_ce && i_reg_rd && i_reg_idx == 5'h07 |=> o_reg_err) else $error("err");
endmodule
bind aabm_match aabm_match_sva u_chk (.i_clk(i_clk), .i_resetn(i_resetn),
  .i_ce(i_ce), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .i_reg_idx(i_reg_idx), .o_reg_err(o_reg_err), .i_cmd_load(i_cmd_load),
  .i_cmd_attr(i_cmd_attr), .o_cmd_type(o_cmd_type),
  .o_cmd_modifier(o_cmd_modifier), .i_bus_valid(i_bus_valid),
  .o_attr_hit(o_attr_hit), .o_addr_hit(o_addr_hit),
  .o_hit_valid(o_hit_valid), .o_mod_class(o_mod_class),
  .o_int_level(o_int_level));

// file: aabm_bus_model.sv
// Local bus partner that presents one transfer per call.
`timescale 1ns/1ps
module aabm_bus_model
(
  input wire i_clk,
  output reg o_valid,
  output reg [31:0] o_addr,
  output reg [7:0] o_attr
);
  initial
  begin
    o_valid = 1'b0;
    o_addr = 32'h0;
    o_attr = 8'h0;
  end
  // Released lines show the inverse of the last value, never a stale copy.
  task send(input [31:0] a, input [7:0] t);
  begin
    @(negedge i_clk);
    o_valid = 1'b1;
    o_addr = a;
    o_attr = t;
    @(negedge i_clk);
    o_valid = 1'b0;
    o_addr = ~a;
    o_attr = ~t;
  end
  endtask
endmodule

// file: aabm_match_tb_top.sv
// Self-checking testbench for the breakpoint comparator.
`timescale 1ns/1ps
module aabm_match_tb_top;
  reg i_clk = 1'b0, i_resetn = 1'b0, wr = 1'b0, rd = 1'b0, ld = 1'b0;
  reg ce = 1'b1;
  reg [4:0] idx = 5'h00;
  reg [31:0] wd = 32'h0, ca = 32'h0, a;
  reg [7:0] ct = 8'h00;
  reg [1:0] md = 2'h0;
  wire [31:0] rdat, baddr, cadr;
  wire err, bv, ah, dh, hv, crd;
  wire [7:0] bat;
  wire [1:0] cty, csz;
  wire [2:0] cmo, mcl, ilv;
  integer n_mismatch = 0, checks_done = 0, i, j;
  aabm_bus_model u_aabm_bus_model (.i_clk(i_clk), .o_valid(bv),
    .o_addr(baddr), .o_attr(bat));
  aabm_match u_aabm_match (.i_clk(i_clk), .i_resetn(i_resetn), .i_ce(ce),
    .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_idx(idx), .i_reg_wdata(wd),
    .o_reg_rdata(rdat), .o_reg_err(err), .i_cmd_load(ld), .i_cmd_addr(ca),
    .i_cmd_attr(ct), .o_cmd_addr(cadr), .o_cmd_type(cty),
    .o_cmd_modifier(cmo), .o_cmd_size(csz), .o_cmd_read(crd),
    .i_addr_mode(md), .i_bus_valid(bv), .i_bus_addr(baddr),
    .i_bus_read(bat[7]), .i_bus_size(bat[6:5]), .i_bus_type(bat[4:3]),
    .i_bus_modifier(bat[2:0]), .o_attr_hit(ah), .o_addr_hit(dh),
    .o_hit_valid(hv), .o_mod_class(mcl), .o_int_level(ilv));
  task cmp(input [31:0] got, input [31:0] exp);
  begin
    checks_done = checks_done + 1;
    if (got !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task acc(input w, input [4:0] x, input [31:0] d);
  begin
    @(negedge i_clk);
    wr = w;
    rd = !w;
    idx = x;
    wd = d;
    @(negedge i_clk);
    wr = 1'b0;
    rd = 1'b0;
  end
  endtask
  task rdc(input [4:0] x, input [31:0] e);
  begin
    acc(1'b0, x, 32'h0);
    cmp(rdat, e);
  end
  endtask
  function [2:0] cls(input [4:0] c);
  begin
    case (c)
      5'h00: cls = 3'h1;
      5'h01: cls = 3'h2;
      5'h02: cls = 3'h3;
      5'h05, 5'h15: cls = 3'h4;
      5'h06, 5'h16: cls = 3'h5;
      5'h18: cls = 3'h6;
      default: cls = (c[4:3] == 2'h3) ? 3'h7 : 3'h0;
    endcase
  end
  endfunction
  task results;
  begin
    if (n_mismatch == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask
  initial
  begin
    forever #2.5 i_clk = ~i_clk;
  end
  initial
  begin
    repeat (4) @(negedge i_clk);
    i_resetn = 1'b1;
    cmp({crd, csz, cty, cmo}, 32'h05);
    rdc(5'h06, 32'h00000005);
    rdc(5'h0C, 32'h0);
    rdc(5'h0D, 32'h0);
    acc(1'b1, 5'h0D, 32'h00000100);
    acc(1'b1, 5'h0C, 32'h80000000);
    rdc(5'h0D, 32'h00000100);
    rdc(5'h0C, 32'h80000000);
    cmp(err, 32'h0);
    ce = 1'b0;
    acc(1'b1, 5'h0D, 32'hDEADBEEF);
    ce = 1'b1;
    rdc(5'h0D, 32'h00000100);
    rdc(5'h07, 32'h0);
    cmp(err, 32'h1);
    for (j = 0; j < 4; j = j + 1)
      for (i = 0; i < 4; i = i + 1)
      begin
        md = j;
        a = i[1] ? 32'h80000000 + i[0] : 32'hFF + i;
        u_aabm_bus_model.send(a, 8'h05);
        cmp({hv, ah, dh}, {2'b11, j == 3 ? 1'b0 : j == 0 ? a == 32'h100 :
          (j == 1) ==
          (a >= 32'h100 && a <= 32'h80000000)});
      end
    for (i = 0; i < 8; i = i + 1)
    begin
      acc(1'b1, 5'h06, 32'hA1);
      u_aabm_bus_model.send(32'h0, 8'hA1 ^ (8'h01 << i));
      cmp(ah, 32'h0);
      acc(1'b1, 5'h06, 32'hA1 | (32'h100 << i));
      u_aabm_bus_model.send(32'h0, 8'hA1 ^ (8'h01 << i));
      cmp(ah, 32'h1);
    end
    for (i = 0; i < 32; i = i + 1)
    begin
      acc(1'b1, 5'h06, i);
      @(negedge i_clk);
      cmp({mcl, ilv}, {cls(i[4:0]),
        i[4:3] == 3 ? i[2:0] : 3'h0});
    end
    acc(1'b1, 5'h06, 32'h00008000);
    ca = 32'h12345678;
    ct = 8'h5A;
    ld = 1'b1;
    @(negedge i_clk);
    ld = 1'b0;
    cmp(cadr, 32'h12345678);
    cmp({crd, csz, cty, cmo}, 32'h5A);
    rdc(5'h0C, 32'h12345678);
    rdc(5'h06, 32'h0000805A);
    results;
  end
endmodule
